// *** verilog/awgrs_pkg.sv ***
// awgrs_pkg: constants and types of the waveform replay sequencer.
// assumes a 32-bit AHB-Lite register port and one 16-bit sample memory.
package awgrs_pkg;
	localparam int AW = 10;
	localparam int DEPTH = 1024;
	localparam int LW = 11;
	localparam int NSEG = 8;
	localparam int SW = 3;
	localparam int DW = 16;
	localparam int SMP_W = 14;
	localparam int HA_W = 13;
	// byte offsets on the register bus
	localparam logic [HA_W-1:0] A_CTRL = 13'h0000;
	localparam logic [HA_W-1:0] A_CMD = 13'h0004;
	localparam logic [HA_W-1:0] A_STAT = 13'h0008;
	localparam logic [HA_W-1:0] A_REPEAT = 13'h000C;
	localparam logic [HA_W-1:0] A_LEN = 13'h0010;
	localparam logic [HA_W-1:0] A_MARK = 13'h0014;
	localparam logic [HA_W-1:0] A_FIFO = 13'h0018;
	localparam logic [HA_W-1:0] A_SEQSEL = 13'h001C;
	localparam logic [HA_W-1:0] A_SEG = 13'h0040;
	localparam logic [HA_W-1:0] A_SEQ = 13'h0060;
	localparam int A_WAVE_BIT = 12;
	// field positions
	localparam int C_MODE = 0;
	localparam int C_GLVL = 3;
	localparam int C_DIG = 4;
	localparam int C_CLK = 5;
	localparam int K_ARM = 0;
	localparam int K_STOP = 1;
	localparam int K_TRIG = 2;
	localparam int K_CLRU = 3;
	localparam int K_JUMP = 4;
	localparam int S_PHASE = 0;
	localparam int S_UNDER = 2;
	localparam int S_FULL = 3;
	localparam int S_SEQ = 4;
	localparam int S_FILL = 16;
	localparam int G_START = 0;
	localparam int G_LEN = 16;
	localparam int Q_SEG = 0;
	localparam int Q_LOOPS = 8;
	localparam int Q_ADV = 16;
	localparam int Q_LAST = 17;
	// reset values and levels
	localparam logic [LW-1:0] DEPTH_L = 11'h400;
	localparam logic [LW-1:0] LEN_RST = DEPTH_L;
	localparam logic [15:0] REPEAT_RST = 16'h0001;
	localparam logic [LW-1:0] STREAM_LOW = 11'h200;

	typedef enum logic [2:0] {
		M_SINGLE = 3'b000,
		M_REPEAT = 3'b001,
		M_RESTART = 3'b010,
		M_STREAM = 3'b011,
		M_MULTI = 3'b100,
		M_GATED = 3'b101,
		M_SEQ = 3'b110
	} awgrs_mode_t;

	typedef enum logic [1:0] {
		P_IDLE = 2'b00,
		P_ARMED = 2'b01,
		P_PLAY = 2'b10
	} awgrs_phase_t;

	typedef struct packed {
		logic en;
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
	} awgrs_memwr_t;

	typedef struct packed {
		logic [LW-1:0] len;
		logic [AW-1:0] start;
	} awgrs_seg_t;

	typedef struct packed {
		logic last;
		logic adv;
		logic [7:0] loops;
		logic [SW-1:0] seg;
	} awgrs_seq_t;

	typedef struct packed {
		awgrs_phase_t phase;
		awgrs_mode_t mode;
		logic gateLvl;
		logic digEn;
		logic clkExt;
		logic [15:0] repeatN;
		logic [15:0] passCnt;
		logic [LW-1:0] len;
		logic [LW-1:0] marker;
		logic [LW-1:0] off;
		logic [LW-1:0] curLen;
		logic [LW-1:0] count;
		logic [AW-1:0] base;
		logic [AW-1:0] wrPtr;
		logic [SW-1:0] seqSel;
		logic [SW-1:0] seqIdx;
		logic [7:0] loopCnt;
		logic jumpPend;
		logic underrun;
		logic trigPrev;
		awgrs_seg_t [NSEG-1:0] segTab;
		awgrs_seq_t [NSEG-1:0] seqTab;
		logic dWr;
		logic dRd;
		logic [HA_W-1:0] dAddr;
		logic hreadyout;
		logic [31:0] hrdata;
		logic issue;
		logic mark;
		logic valid;
		logic markOut;
		logic streamReq;
		logic [SMP_W-1:0] dac;
		logic [1:0] dig;
	} awgrs_st_t;
endpackage

// *** verilog/awgrs_wave_mem.sv ***
// awgrs_wave_mem: sample memory, one write port and one registered read.
// assumes both ports share sys_clk and the clock enable of the sequencer.
`timescale 1ns/100ps
`default_nettype none
module awgrs_wave_mem import awgrs_pkg::*; (
	input wire logic sys_clk,
	input wire logic ce,
	input wire awgrs_memwr_t wr,
	input wire logic [AW-1:0] rdAddr,
	output logic [DW-1:0] rdData
);
	logic [DW-1:0] mem [DEPTH];

	// writes land while other addresses are being replayed
	always_ff @(posedge sys_clk) begin
		if (ce) begin
			if (wr.en) begin
				mem[wr.addr] <= wr.data;
			end
			rdData <= mem[rdAddr];
		end
	end
endmodule
`default_nettype wire

// *** verilog/awgrs_sequencer.sv ***
// awgrs_sequencer: replay controller of the waveform generator.
// assumes an AHB-Lite master, trigger and gate synchronous to sys_clk.
// What this block does
// - single shot plays once on first trigger, later triggers ignored
// - repeated mode loops for repeat count or until stop
// - repeated mode ignores triggers after the starting one
// - restart mode plays whole memory once per trigger
// - streaming uses the whole memory as a buffer
// - streaming raises a request to the host when fill runs low
// - multiple mode splits memory into equal segments
// - multiple mode plays next segment per trigger without restart
// - gated mode plays only while gate is at programmed level
// - sequence mode plays segments of own length in table order
// - each sequence entry names segment and loop count
// - sequence entry may wait for trigger before advancing
// - one software command switches the active sequence entry
// - sample memory accepts writes while other segments play
// - repeated portions are stored once and replayed in loops
// - marker output is aligned with the outgoing samples
// - digital outputs come from two spare bits of each word
// - sample clock source selectable internal or external
`timescale 1ns/100ps
`default_nettype none
module awgrs_sequencer import awgrs_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic hwrite,
	input wire logic [1:0] htrans,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic trigIn,
	input wire logic gateIn,
	output logic [SMP_W-1:0] dacData,
	output logic dacValid,
	output logic [1:0] digOut,
	output logic markerOut,
	output logic streamReq,
	output logic clkSelExt
);
	awgrs_st_t s;
	awgrs_st_t n;
	awgrs_memwr_t memWr;
	logic [DW-1:0] memRd;
	logic [AW-1:0] rdAddr;
	logic cmdWr;
	logic cmdArm;
	logic cmdStop;
	logic swTrig;
	logic trg;
	logic gateOk;
	logic fire;
	logic last;
	logic push;
	logic pop;
	logic [11:0] nb;
	logic [SW-1:0] nIdx;
	awgrs_seq_t ent;
	awgrs_seq_t nEnt;
	awgrs_seg_t nSeg;
	logic [31:0] rd;

	awgrs_wave_mem u_mem (
		.sys_clk(sys_clk),
		.ce(ce),
		.wr(memWr),
		.rdAddr(rdAddr),
		.rdData(memRd)
	);

	always_comb begin
		n = s;
		memWr = '0;
		rd = 32'h0000_0000;
		ent = s.seqTab[s.seqIdx];
		cmdWr = s.dWr && s.dAddr == A_CMD;
		cmdArm = cmdWr && hwdata[K_ARM];
		cmdStop = cmdWr && hwdata[K_STOP];
		swTrig = cmdWr && hwdata[K_TRIG];
		trg = (trigIn && !s.trigPrev) || swTrig;
		gateOk = gateIn == s.gateLvl;
		fire = s.phase == P_PLAY && (s.mode != M_GATED || gateOk)
			&& (s.mode != M_STREAM || s.count != '0);
		last = s.mode != M_STREAM && s.off + 11'h001 == s.curLen;
		rdAddr = AW'(s.base + s.off[AW-1:0]);
		push = 1'b0;
		pop = fire && s.mode == M_STREAM;
		nb = {2'b00, s.base} + {1'b0, s.curLen};
		nIdx = (s.jumpPend || ent.last) ? s.seqSel : SW'(s.seqIdx + 3'h1);
		nEnt = s.seqTab[nIdx];
		nSeg = s.segTab[nEnt.seg];
		if (ce) begin
			// bus address phase
			n.dWr = hsel && hready && htrans[1] && hwrite;
			n.dRd = hsel && hready && htrans[1] && !hwrite;
			n.dAddr = haddr[HA_W-1:0];
			if (n.dRd) begin
				n.hreadyout = 1'b0;
			end
			// register read data, one wait state
			case (s.dAddr)
				A_CTRL: begin
					rd[C_MODE +: 3] = s.mode;
					rd[C_GLVL] = s.gateLvl;
					rd[C_DIG] = s.digEn;
					rd[C_CLK] = s.clkExt;
				end
				A_STAT: begin
					rd[S_PHASE +: 2] = s.phase;
					rd[S_UNDER] = s.underrun;
					rd[S_FULL] = s.count == DEPTH_L;
					rd[S_SEQ +: SW] = s.seqIdx;
					rd[S_FILL +: LW] = s.count;
				end
				A_REPEAT: rd[15:0] = s.repeatN;
				A_LEN: rd[LW-1:0] = s.len;
				A_MARK: rd[LW-1:0] = s.marker;
				A_SEQSEL: rd[SW-1:0] = s.seqSel;
				default: begin
					if (s.dAddr[12:5] == A_SEG[12:5]) begin
						rd[G_START +: AW] = s.segTab[s.dAddr[4:2]].start;
						rd[G_LEN +: LW] = s.segTab[s.dAddr[4:2]].len;
					end else if (s.dAddr[12:5] == A_SEQ[12:5]) begin
						rd[Q_SEG +: SW] = s.seqTab[s.dAddr[4:2]].seg;
						rd[Q_LOOPS +: 8] = s.seqTab[s.dAddr[4:2]].loops;
						rd[Q_ADV] = s.seqTab[s.dAddr[4:2]].adv;
						rd[Q_LAST] = s.seqTab[s.dAddr[4:2]].last;
					end
				end
			endcase
			if (s.dRd) begin
				n.hrdata = rd;
				n.hreadyout = 1'b1;
			end
			// register writes in the data phase
			if (s.dWr) begin
				case (s.dAddr)
					A_CTRL: begin
						n.mode = awgrs_mode_t'(hwdata[C_MODE +: 3]);
						n.gateLvl = hwdata[C_GLVL];
						n.digEn = hwdata[C_DIG];
						n.clkExt = hwdata[C_CLK];
					end
					A_REPEAT: n.repeatN = hwdata[15:0];
					A_LEN: n.len = hwdata[LW-1:0];
					A_MARK: n.marker = hwdata[LW-1:0];
					A_SEQSEL: n.seqSel = hwdata[SW-1:0];
					A_FIFO: begin
						push = s.count != DEPTH_L;
						memWr = '{en: push, addr: s.wrPtr,
							data: hwdata[DW-1:0]};
						n.wrPtr = AW'(s.wrPtr + {9'h000, push});
					end
					default: begin
						if (s.dAddr[A_WAVE_BIT]) begin
							memWr = '{en: 1'b1, addr: s.dAddr[11:2],
								data: hwdata[DW-1:0]};
						end else if (s.dAddr[12:5] == A_SEG[12:5]) begin
							n.segTab[s.dAddr[4:2]] = '{
								len: hwdata[G_LEN +: LW],
								start: hwdata[G_START +: AW]};
						end else if (s.dAddr[12:5] == A_SEQ[12:5]) begin
							n.seqTab[s.dAddr[4:2]] = '{
								last: hwdata[Q_LAST], adv: hwdata[Q_ADV],
								loops: hwdata[Q_LOOPS +: 8],
								seg: hwdata[Q_SEG +: SW]};
						end
					end
				endcase
			end
			n.count = LW'(s.count + {10'h000, push} - {10'h000, pop});
			// replay engine
			case (s.phase)
				P_ARMED: begin
					if (trg) begin
						n.phase = P_PLAY;
						n.off = '0;
						if (s.mode == M_SEQ) begin
							n.base = s.segTab[ent.seg].start;
							n.curLen = s.segTab[ent.seg].len;
							n.loopCnt = '0;
						end
					end
				end
				P_PLAY: begin
					if (fire) begin
						n.off = LW'(s.off + 11'h001);
						if (s.mode == M_STREAM) begin
							n.base = AW'(s.base + 10'h001);
							n.off = '0;
						end
					end
					if (fire && last) begin
						case (s.mode)
							M_SINGLE: n.phase = P_IDLE;
							M_REPEAT: begin
								if (s.repeatN == '0 ||
									s.passCnt + 16'h0001 < s.repeatN) begin
									n.off = '0;
									n.passCnt = 16'(s.passCnt + 16'h0001);
								end else begin
									n.phase = P_IDLE;
								end
							end
							M_RESTART: n.phase = P_ARMED;
							M_MULTI: begin
								// equal segments of len words, wrap at the top
								n.base = (nb + {1'b0, s.curLen}) > 12'h400
									? '0 : nb[AW-1:0];
								n.phase = P_ARMED;
							end
							M_GATED: n.off = '0;
							M_SEQ: begin
								n.off = '0;
								if ({1'b0, s.loopCnt} + 9'h001
									< {1'b0, ent.loops}) begin
									n.loopCnt = 8'(s.loopCnt + 8'h01);
								end else begin
									n.loopCnt = '0;
									n.seqIdx = nIdx;
									n.jumpPend = 1'b0;
									n.base = nSeg.start;
									n.curLen = nSeg.len;
									if (ent.adv) begin
										n.phase = P_ARMED;
									end
								end
							end
							default: n.phase = P_IDLE;
						endcase
					end
				end
				default: n.phase = P_IDLE;
			endcase
			if (cmdWr && hwdata[K_JUMP]) begin
				n.jumpPend = 1'b1;
			end
			if (cmdArm) begin
				n.off = '0;
				n.passCnt = '0;
				n.loopCnt = '0;
				n.base = '0;
				n.curLen = s.mode == M_RESTART ? DEPTH_L : s.len;
				n.seqIdx = s.seqSel;
				n.jumpPend = 1'b0;
				n.phase = s.mode == M_GATED ? P_PLAY : P_ARMED;
				if (s.mode == M_STREAM) begin
					n.wrPtr = '0;
					n.count = '0;
				end
			end
			if (cmdStop) begin
				n.phase = P_IDLE;
			end
			if (cmdWr && hwdata[K_CLRU]) begin
				n.underrun = 1'b0;
			end
			if (s.mode == M_STREAM && s.phase == P_PLAY && s.count == '0) begin
				n.underrun = 1'b1;
			end
			n.streamReq = s.mode == M_STREAM && s.phase != P_IDLE
				&& s.count < STREAM_LOW;
			// output stage, one cycle behind the memory read
			n.issue = fire;
			n.mark = fire && s.off == s.marker;
			n.valid = s.issue;
			n.markOut = s.issue && s.mark;
			if (s.issue) begin
				n.dac = memRd[SMP_W-1:0];
				n.dig = s.digEn ? memRd[DW-1:SMP_W] : 2'b00;
			end
			n.trigPrev = trigIn;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s <= '0;
			s.len <= LEN_RST;
			s.curLen <= LEN_RST;
			s.repeatN <= REPEAT_RST;
			s.hreadyout <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign hreadyout = s.hreadyout;
	assign hresp = 1'b0;
	assign hrdata = s.hrdata;
	assign dacData = s.dac;
	assign dacValid = s.valid;
	assign digOut = s.dig;
	assign markerOut = s.markOut;
	assign streamReq = s.streamReq;
	assign clkSelExt = s.clkExt;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_fire_out;
		ce && fire ##1 ce;
	endsequence

	sequence s_mark_out;
		ce && fire && s.off == s.marker ##1 ce;
	endsequence

	a_single_once: assert property (
		ce && s.mode == M_SINGLE && fire && last && !cmdWr
		|=> s.phase == P_IDLE ##1 s.phase == P_IDLE || $past(cmdWr))
		else $error("single shot did not stop after one pass");
	a_repeat_count: assert property (
		ce && s.mode == M_REPEAT && fire && last && !cmdWr
		&& s.repeatN != '0 && s.passCnt + 16'h0001 >= s.repeatN
		|=> s.phase == P_IDLE)
		else $error("repeat count not honoured");
	a_repeat_ignore: assert property (
		ce && s.mode == M_REPEAT && fire && !last && trg && !cmdWr
		|=> s.off == $past(s.off) + 11'h001 && s.phase == P_PLAY)
		else $error("trigger restarted repeated output");
	a_restart_rearm: assert property (
		ce && s.mode == M_RESTART && fire && last && !cmdWr
		|=> s.phase == P_ARMED && s.curLen == DEPTH_L)
		else $error("restart mode did not rearm");
	a_multi_step: assert property (
		ce && s.mode == M_MULTI && fire && last && !cmdWr
		|=> s.phase == P_ARMED && s.base != $past(s.base))
		else $error("multiple mode did not step segment");
	a_gate_hold: assert property (
		ce && s.mode == M_GATED && s.phase == P_PLAY && !gateOk && !cmdWr
		|=> $stable(s.off) && !s.issue)
		else $error("replay ran with gate inactive");
	a_seq_loop: assert property (
		ce && s.mode == M_SEQ && fire && last && !cmdWr
		&& {1'b0, s.loopCnt} + 9'h001 < {1'b0, ent.loops}
		|=> s.off == '0 && s.loopCnt == $past(s.loopCnt) + 8'h01)
		else $error("sequence loop count wrong");
	a_sample_out: assert property (
		s_fire_out |=> s.valid && s.dac == $past(memRd[SMP_W-1:0]))
		else $error("sample not presented two cycles after read");
	a_marker_sync: assert property (
		s_mark_out |=> markerOut && dacValid)
		else $error("marker out of step with samples");
	a_underrun_sticky: assert property (
		ce && s.underrun && !(cmdWr && hwdata[K_CLRU]) |=> s.underrun)
		else $error("underrun flag lost without clear");
	a_stream_req: assert property (
		ce && s.mode == M_STREAM && s.phase == P_PLAY && s.count < STREAM_LOW
		|=> streamReq)
		else $error("no host request at low fill");
endmodule
`default_nettype wire

// *** dv/awgrs_host_model.sv ***
// awgrs_host_model: host side of the sequencer, an AHB-Lite master.
// assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/100ps
`default_nettype none
module awgrs_host_model import awgrs_pkg::*; (
	input wire logic sys_clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic hwrite,
	output logic [1:0] htrans,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		hwrite = 1'b0;
		htrans = 2'b00;
		hsize = 3'b010;
		hwdata = 32'h0;
	end

	// bounded wait for hready sampled high at a rising edge
	task automatic waitRdy(output bit ok);
		int i;
		ok = 1'b0;
		for (i = 0; i < 16 && !ok; i++) begin
			@(posedge sys_clk);
			ok = (hready === 1'b1);
		end
	endtask

	task automatic xfer(input logic [HA_W-1:0] a, input logic [31:0] wd,
		input bit wr, output logic [31:0] rd, output bit ok);
		hsel <= 1'b1;
		haddr <= {19'h0, a};
		hwrite <= wr;
		htrans <= 2'b10;
		hsize <= 3'b010;
		waitRdy(ok);
		htrans <= 2'b00;
		hwdata <= wr ? wd : ~hwdata;
		if (ok)
			waitRdy(ok);
		rd = hrdata;
	endtask
endmodule
`default_nettype wire

// *** dv/tb_awgrs_sequencer.sv ***
// tb_awgrs_sequencer: replay modes driven through register calls.
// assumes the host model as bus master and trigger/gate from the bench.
`timescale 1ns/100ps
`default_nettype none
module tb_awgrs_sequencer import awgrs_pkg::*;;
	logic sys_clk, rst, ce, hsel, hwrite, hready, hreadyout, hresp;
	logic trigIn, gateIn, dacValid, markerOut, streamReq, clkSelExt;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [1:0] htrans, digOut;
	logic [2:0] hsize;
	logic [SMP_W-1:0] dacData;
	logic [15:0] smp[$];
	int errors, n_compared, markIdx, i;

	assign hready = hreadyout;

	awgrs_sequencer u_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce),
		.hsel(hsel), .haddr(haddr), .hwrite(hwrite), .htrans(htrans),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.trigIn(trigIn), .gateIn(gateIn), .dacData(dacData),
		.dacValid(dacValid), .digOut(digOut), .markerOut(markerOut),
		.streamReq(streamReq), .clkSelExt(clkSelExt));

	awgrs_host_model u_host (.sys_clk(sys_clk), .hready(hready),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .hwrite(hwrite),
		.htrans(htrans), .hsize(hsize), .hwdata(hwdata));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// capture every presented sample with its spare bits
	always @(posedge sys_clk) begin
		// a sample frozen by ce counts once, at the edge that releases it
		if (!rst && ce && dacValid === 1'b1) begin
			if (markerOut === 1'b1 && markIdx < 0)
				markIdx = smp.size();
			smp.push_back({digOut, dacData});
		end
	end

	function automatic logic [15:0] wv(input int k);
		return {k[1:0], 14'h0100 + k[13:0]};
	endfunction

	task automatic final_report();
		$display("errors=%0d n_compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic [HA_W-1:0] a, input logic [31:0] wd,
		input bit wr, output logic [31:0] rd);
		bit ok;
		u_host.xfer(a, wd, wr, rd, ok);
		if (!ok) begin
			errors++;
			$display("Error %0t: bus transfer timed out", $time);
			final_report();
		end
	endtask

	task automatic wr(input logic [HA_W-1:0] a, input logic [31:0] wd);
		logic [31:0] x;
		bus(a, wd, 1'b1, x);
	endtask

	task automatic trig();
		trigIn <= 1'b1;
		@(posedge sys_clk);
		trigIn <= 1'b0;
		@(posedge sys_clk);
	endtask

	// stop, configure mode and length, then arm
	task automatic cfg(input awgrs_mode_t m, input logic [31:0] len,
		input logic [31:0] x);
		wr(A_CMD, 32'h2);
		wr(A_CTRL, 32'h10 | x | 32'(m));
		wr(A_LEN, len);
		smp.delete();
		markIdx = -1;
		wr(A_CMD, 32'h1);
	endtask

	task automatic waitN(input int n, input bit exact);
		int k;
		for (k = 0; k < 2500 && smp.size() < n; k++)
			@(posedge sys_clk);
		if (smp.size() < n) begin
			errors++;
			$display("Error %0t: samples missing", $time);
			final_report();
		end
		repeat (30) @(posedge sys_clk);
		if (exact)
			chk(32'(smp.size()), 32'(n));
	endtask

	task automatic chkS(input int idx, input int k);
		chk({16'h0, smp[idx]}, {16'h0, wv(k)});
	endtask

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		trigIn = 1'b0;
		gateIn = 1'b0;
		markIdx = -1;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		bus(A_CTRL, 32'h0, 1'b0, d);
		chk(d, 32'h0);
		bus(A_LEN, 32'h0, 1'b0, d);
		chk(d, 32'h400);
		bus(A_REPEAT, 32'h0, 1'b0, d);
		chk(d, 32'h1);
		bus(13'h0030, 32'h0, 1'b0, d);
		chk(d, 32'h0);
		wr(A_CTRL, 32'h20);
		repeat (2) @(posedge sys_clk);
		chk(32'(clkSelExt), 32'h1);
		for (i = 0; i < 1024; i++)
			wr(13'h1000 + 13'(4 * i), {16'h0, wv(i)});
		// single shot, marker on the second sample
		wr(A_MARK, 32'h1);
		cfg(M_SINGLE, 32'h4, 32'h0);
		trig();
		waitN(4, 1'b1);
		for (i = 0; i < 4; i++)
			chkS(i, i);
		chk(32'(markIdx), 32'h1);
		trig();
		waitN(4, 1'b1);
		// repeated output, two passes, extra trigger ignored
		wr(A_REPEAT, 32'h2);
		cfg(M_REPEAT, 32'h4, 32'h0);
		trig();
		trig();
		waitN(8, 1'b1);
		for (i = 0; i < 8; i++)
			chkS(i, i % 4);
		// restart replays the whole memory once per trigger
		cfg(M_RESTART, 32'h4, 32'h0);
		wr(A_CMD, 32'h4);
		waitN(1024, 1'b1);
		chkS(1023, 1023);
		wr(A_CMD, 32'h4);
		waitN(2048, 1'b1);
		chkS(1024, 0);
		// multiple replay, one equal segment per trigger
		cfg(M_MULTI, 32'h2, 32'h0);
		trig();
		waitN(2, 1'b1);
		trig();
		waitN(4, 1'b1);
		for (i = 0; i < 4; i++)
			chkS(i, i);
		// gated replay at active-high gate level
		cfg(M_GATED, 32'h4, 32'h8);
		repeat (20) @(posedge sys_clk);
		chk(32'(smp.size()), 32'h0);
		gateIn <= 1'b1;
		waitN(4, 1'b0);
		// clock enable low freezes replay and the output word
		ce <= 1'b0;
		@(posedge sys_clk);
		d = 32'(dacData);
		repeat (20) @(posedge sys_clk);
		chk(32'(dacData), d);
		ce <= 1'b1;
		// word 4 is rewritten while words 0-3 keep playing
		wr(13'h1010, {16'h0, wv(12)});
		gateIn <= 1'b0;
		repeat (10) @(posedge sys_clk);
		i = smp.size();
		repeat (20) @(posedge sys_clk);
		chk(32'(smp.size()), 32'(i));
		chkS(0, 0);
		chkS(i - 1, (i - 1) % 4);
		// streaming: two words fed, then underrun
		cfg(M_STREAM, 32'h4, 32'h0);
		repeat (2) @(posedge sys_clk);
		chk(32'(streamReq), 32'h1);
		chk(32'(hresp), 32'h0);
		wr(A_FIFO, {16'h0, wv(5)});
		wr(A_FIFO, {16'h0, wv(6)});
		wr(A_CMD, 32'h4);
		waitN(2, 1'b1);
		chkS(0, 5);
		chkS(1, 6);
		bus(A_STAT, 32'h0, 1'b0, d);
		chk(32'(d[2]), 32'h1);
		wr(A_CMD, 32'h2);
		wr(A_CMD, 32'h8);
		bus(A_STAT, 32'h0, 1'b0, d);
		chk(32'(d[2]), 32'h0);
		// sequence: entry 0 plays words 2-3 twice then waits for a trigger,
		// entry 1 plays word 4 once and links back to entry 0
		wr(A_SEG, 32'h0002_0002);
		wr(A_SEG + 13'h4, 32'h0001_0004);
		wr(A_SEQ, 32'h0001_0200);
		wr(A_SEQ + 13'h4, 32'h0002_0001);
		wr(A_SEQSEL, 32'h0);
		cfg(M_SEQ, 32'h4, 32'h0);
		// pending jump sends the end of entry 0 back to entry 0
		wr(A_CMD, 32'h10);
		trig();
		waitN(4, 1'b1);
		bus(A_STAT, 32'h0, 1'b0, d);
		chk(32'(d[1:0]), 32'h1);
		chk(32'(d[6:4]), 32'h0);
		trig();
		waitN(8, 1'b1);
		trig();
		waitN(13, 1'b1);
		chkS(0, 2);
		chkS(3, 3);
		chkS(7, 3);
		chkS(8, 12);
		chkS(9, 2);
		chkS(12, 3);
		wr(A_CMD, 32'h2);
		final_report();
	end
endmodule
`default_nettype wire
